/* File: pfp_ctrl_model.sv */
// Purpose: controller side of the open-drain status pins, with pull-ups
// Assumes: a driven pin is pulled to its out value, a released pin floats to high
// Notes:   coolReq only flags the wish to cut power; nothing acts on it here
`timescale 1ns/100ps
module pfp_ctrl_model
(
   input  wire logic faultAlertOut_n,
   input  wire logic faultAlertOe,
   input  wire logic thermalWarningOut_n,
   input  wire logic thermalWarningOe,
   output logic      alertPin_n,
   output logic      warnPin_n,
   output logic      coolReq
);
   // released pin reads the pull-up level, never the last driven value
   assign alertPin_n = faultAlertOe ? faultAlertOut_n : 1'b1;
   assign warnPin_n  = thermalWarningOe ? thermalWarningOut_n : 1'b1;
   assign coolReq    = ~warnPin_n;
endmodule : pfp_ctrl_model

/* File: pfp_pkg.sv */
// Purpose: shared constants and types for the power stage fault protection block
// Assumes: 100 MHz clock, register port with 4-bit byte address
// Notes:   output configuration codes are software values, not pin straps
package pfp_pkg;
   // output configuration
   localparam logic [1:0] MODE_BRIDGE_TIED     = 2'h0;
   localparam logic [1:0] MODE_PARALLEL_BRIDGE = 2'h1;
   localparam logic [1:0] MODE_SINGLE_ENDED    = 2'h2;

   // register map
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;

   // config fields
   localparam int         CFG_MODE_LSB   = 0;
   localparam int         CFG_CAP_LSB    = 8;
   localparam int         CFG_CAP_W      = 8;
   localparam logic [1:0] CFG_MODE_RESET = MODE_BRIDGE_TIED;
   localparam logic [7:0] CFG_CAP_RESET  = 8'h01;

   // status fields
   localparam int STS_STATE_LSB = 0;
   localparam int STS_HIZ_LSB   = 4;
   localparam int STS_TRIP_BIT  = 8;
   localparam int STS_OVL_LSB   = 12;
   localparam int STS_ALERT_BIT = 16;
   localparam int STS_WARN_BIT  = 17;

   // pin short check timing: ms per uF of output filter capacitance
   localparam int CLK_HZ            = 100_000_000;
   localparam int PSC_MS_PER_UF     = 15;
   localparam int PSC_STEPS         = 2;
   localparam int PSC_CYCLES_PER_UF = (PSC_MS_PER_UF * (CLK_HZ / 1000)) / PSC_STEPS;

   typedef enum logic [2:0]
   {
      ST_POWER_ON,
      ST_SHORT_GND,
      ST_SHORT_SUPPLY,
      ST_SHORT_HOLD,
      ST_RUN
   } pfp_state_t;
endpackage : pfp_pkg

/* File: pfp_protect.sv */
// Purpose: fault gathering, pin short start-up check and status pin control
// Assumes: comparator flags are digital levels, high while the condition holds
// Notes:   alert and warning pins are open drain, pulled up outside this logic
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps

module pfp_protect
   import pfp_pkg::*;
#(
   parameter int PSC_CYCLES = PSC_CYCLES_PER_UF
)
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [3:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdata,
   input  wire logic        resetPin_n,
   input  wire logic        logicSupplyLow,
   input  wire logic        gateSupplyLow,
   input  wire logic        outputSupplyLow,
   input  wire logic        tempWarn,
   input  wire logic        tempTrip,
   input  wire logic        shortToGnd,
   input  wire logic        shortToSupply,
   input  wire logic [3:0]  bootstrapLow,
   input  wire logic [3:0]  overload,
   input  wire logic [3:0]  pwmStuck,
   output logic      [3:0]  halfBridgeHiZ,
   output logic      [3:0]  highSideOff,
   input  wire logic        faultAlertIn_n,
   output logic             faultAlertOut_n,
   output logic             faultAlertOe,
   input  wire logic        thermalWarningIn_n,
   output logic             thermalWarningOut_n,
   output logic             thermalWarningOe
);
   localparam int SYNC_W = 20;

   logic [SYNC_W-1:0] syncIn;
   logic [SYNC_W-1:0] syncOut;
   logic              resetPinS;
   logic              logicLowS;
   logic              gateLowS;
   logic              outLowS;
   logic              warnS;
   logic              tripS;
   logic              shortGndS;
   logic              shortSupS;
   logic [3:0]        bootS;
   logic [3:0]        overloadS;
   logic [3:0]        stuckS;

   logic [1:0]        cfgMode_q;
   logic [7:0]        cfgCap_q;
   pfp_state_t        state_q;
   pfp_state_t        state_d;
   logic [31:0]       stepCnt_q;
   logic [31:0]       stepTarget;
   logic              stepDone;
   logic              checking;
   logic              uvAny;
   logic              globalOff;
   logic              tripLatch_q;
   logic [3:0]        overloadLatch_q;
   logic [3:0]        hiZ_d;
   logic [3:0]        halfBridgeHiZ_q;
   logic [3:0]        highSideOff_q;
   logic              alertLow_d;
   logic              alertLow_q;
   logic              warnLow_q;
   logic [31:0]       regRdata_q;
   logic [1:0]        syncWarm_q;

   if (PSC_CYCLES < 1)
   begin : g_chk
      $error("pfp_protect: PSC_CYCLES must be at least 1");
   end

   // overload on a channel shuts its pair, or every channel when paralleled
   function automatic logic [3:0] groupOff(input logic [3:0] ch, input logic [1:0] mode);
      logic [3:0] off;
      off = {{2{|ch[3:2]}}, {2{|ch[1:0]}}};
      if (mode == MODE_PARALLEL_BRIDGE)
      begin
         off = {4{|ch}};
      end
      return off;
   endfunction : groupOff

   // analog flags arrive from other supply domains, so all pass a synchroniser
   assign syncIn = {resetPin_n, logicSupplyLow, gateSupplyLow, outputSupplyLow,
                    tempWarn, tempTrip, shortToGnd, shortToSupply,
                    bootstrapLow, overload, pwmStuck};

   pfp_sync #(.WIDTH(SYNC_W)) u_sync
   (
      .clk   (clk),
      .reset (reset),
      .din   (syncIn),
      .dout  (syncOut)
   );

   assign {resetPinS, logicLowS, gateLowS, outLowS, warnS, tripS, shortGndS,
           shortSupS, bootS, overloadS, stuckS} = syncOut;

   assign uvAny     = logicLowS | gateLowS | outLowS;
   assign checking  = (state_q == ST_SHORT_GND) || (state_q == ST_SHORT_SUPPLY) ||
                      (state_q == ST_SHORT_HOLD);
   assign globalOff = checking || (state_q == ST_POWER_ON) || uvAny || tripS ||
                      tripLatch_q || !resetPinS;

   // configuration register
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cfgMode_q <= CFG_MODE_RESET;
         cfgCap_q  <= CFG_CAP_RESET;
      end
      else if (regWr && (regAddr == ADDR_CONFIG))
      begin
         cfgMode_q <= regWdata[CFG_MODE_LSB +: 2];
         cfgCap_q  <= regWdata[CFG_CAP_LSB +: CFG_CAP_W];
      end
   end

   // each step lasts capacitance times the per-uF figure, at least one cycle
   assign stepTarget = 32'(cfgCap_q) * 32'(PSC_CYCLES);
   assign stepDone   = (stepCnt_q + 32'h1) >= stepTarget;

   // synchroniser outputs read zero for two edges after reset, which looks like good supplies
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         syncWarm_q <= '0;
      else
         syncWarm_q <= {syncWarm_q[0], 1'b1};
   end

   // start-up sequencing; the reset pin is not looked at here at all
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_POWER_ON:
         begin
            if (!uvAny && syncWarm_q[1])
            begin
               if (cfgMode_q == MODE_SINGLE_ENDED)
               begin
                  state_d = ST_RUN;
               end
               else
               begin
                  state_d = ST_SHORT_GND;
               end
            end
         end
         ST_SHORT_GND:
         begin
            if (shortGndS)
            begin
               state_d = ST_SHORT_HOLD;
            end
            else if (stepDone)
            begin
               state_d = ST_SHORT_SUPPLY;
            end
         end
         ST_SHORT_SUPPLY:
         begin
            if (shortSupS)
            begin
               state_d = ST_SHORT_HOLD;
            end
            else if (stepDone)
            begin
               state_d = ST_RUN;
            end
         end
         ST_SHORT_HOLD:
         begin
            if (!shortGndS && !shortSupS)
            begin
               state_d = ST_RUN;
            end
         end
         ST_RUN:
         begin
            state_d = ST_RUN;
         end
         default:
         begin
            state_d = ST_POWER_ON;
         end
      endcase
      // only a collapse of the logic supply brings back power-on
      if (logicLowS)
      begin
         state_d = ST_POWER_ON;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_q <= ST_POWER_ON;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         stepCnt_q <= '0;
      end
      else if (state_d != state_q)
      begin
         stepCnt_q <= '0;
      end
      else if ((state_q == ST_SHORT_GND) || (state_q == ST_SHORT_SUPPLY))
      begin
         stepCnt_q <= stepCnt_q + 32'h1;
      end
   end

   // thermal trip latch: set wins over the reset-pin clear
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         tripLatch_q <= 1'b0;
      end
      else if (tripS)
      begin
         tripLatch_q <= 1'b1;
      end
      else if (!resetPinS && !checking)
      begin
         tripLatch_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         overloadLatch_q <= '0;
      end
      else if (logicLowS)
      begin
         overloadLatch_q <= '0;
      end
      else if (|overloadS)
      begin
         overloadLatch_q <= overloadLatch_q | overloadS;
      end
      else if (!resetPinS && !checking)
      begin
         overloadLatch_q <= '0;
      end
   end

   // stuck pwm shuts only its own channel and never reaches the alert pin
   assign hiZ_d = globalOff ? 4'hf
                : (groupOff(overloadLatch_q, cfgMode_q) | stuckS);

   // alert follows live undervoltage but latched trip and overload, so undervoltage recovers on its own
   assign alertLow_d = checking ||
                       (resetPinS && (uvAny || tripS || tripLatch_q ||
                        (|overloadLatch_q) || (state_q == ST_POWER_ON)));

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         halfBridgeHiZ_q <= 4'hf;
         highSideOff_q   <= '0;
         alertLow_q      <= 1'b0;
         warnLow_q       <= 1'b0;
      end
      else
      begin
         halfBridgeHiZ_q <= hiZ_d;
         highSideOff_q   <= bootS & ~hiZ_d;
         alertLow_q      <= alertLow_d;
         warnLow_q       <= warnS;
      end
   end

   // open drain: only ever pull low, the pull-up gives the high level
   assign halfBridgeHiZ       = halfBridgeHiZ_q;
   assign highSideOff         = highSideOff_q;
   assign faultAlertOut_n     = 1'b0;
   assign faultAlertOe        = alertLow_q;
   assign thermalWarningOut_n = 1'b0;
   assign thermalWarningOe    = warnLow_q;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         regRdata_q <= '0;
      end
      else
      begin
         regRdata_q <= '0;
         if (regRd && (regAddr == ADDR_CONFIG))
         begin
            regRdata_q[CFG_MODE_LSB +: 2]       <= cfgMode_q;
            regRdata_q[CFG_CAP_LSB +: CFG_CAP_W] <= cfgCap_q;
         end
         else if (regRd && (regAddr == ADDR_STATUS))
         begin
            regRdata_q[STS_STATE_LSB +: 3] <= state_q;
            regRdata_q[STS_HIZ_LSB +: 4]   <= halfBridgeHiZ_q;
            regRdata_q[STS_TRIP_BIT]       <= tripLatch_q;
            regRdata_q[STS_OVL_LSB +: 4]   <= overloadLatch_q;
            regRdata_q[STS_ALERT_BIT]      <= faultAlertIn_n;
            regRdata_q[STS_WARN_BIT]       <= thermalWarningIn_n;
         end
      end
   end

   assign regRdata = regRdata_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence seqGndPass;
      state_q == ST_SHORT_GND && !shortGndS && stepDone && !logicLowS;
   endsequence

   sequence seqSupplyStep;
      state_q == ST_SHORT_SUPPLY ##1 1'b1;
   endsequence

   sequence seqRunSettled;
      state_q == ST_RUN && !logicLowS && resetPinS;
   endsequence

   chk_uv_hiz_alert: assert property (seqRunSettled ##0 (gateLowS || outLowS)
      |=> halfBridgeHiZ_q == 4'hf && alertLow_q)
      else $error("undervoltage did not force hi-z with alert");

   chk_uv_selfclear: assert property (seqRunSettled ##0 (!uvAny && !tripS &&
      !tripLatch_q && overloadLatch_q == 4'h0 && stuckS == 4'h0) |=> halfBridgeHiZ_q == 4'h0)
      else $error("outputs stayed off without a fault");

   chk_group_btl: assert property (seqRunSettled ##0 (!globalOff &&
      cfgMode_q == MODE_BRIDGE_TIED && overloadLatch_q == 4'h4 && stuckS == 4'h0)
      |=> halfBridgeHiZ_q == 4'hc)
      else $error("bridge tied group shutdown wrong");

   chk_group_parallel_bridge: assert property (seqRunSettled ##0 (!globalOff &&
      cfgMode_q == MODE_PARALLEL_BRIDGE && overloadLatch_q == 4'h1) |=> halfBridgeHiZ_q == 4'hf)
      else $error("parallel bridge did not shut all channels");

   chk_bootstrap_side: assert property (seqRunSettled ##0 (!globalOff &&
      overloadLatch_q == 4'h0 && stuckS == 4'h0 && bootS == 4'h2)
      |=> highSideOff_q == 4'h2 && halfBridgeHiZ_q == 4'h0)
      else $error("bootstrap low did more than drop the high side");

   chk_no_recheck: assert property (seqRunSettled |=> state_q == ST_RUN)
      else $error("pin short check restarted after start-up");

   chk_check_order: assert property (seqGndPass |=> seqSupplyStep)
      else $error("supply step did not follow ground step");

   chk_hold_hiz: assert property (state_q == ST_SHORT_HOLD && shortGndS &&
      !logicLowS |=> state_q == ST_SHORT_HOLD ##0 halfBridgeHiZ_q == 4'hf)
      else $error("short hold released early");

   chk_check_alert: assert property (checking |=> alertLow_q)
      else $error("alert released during pin short check");

   chk_se_skip: assert property (state_q == ST_POWER_ON && !uvAny && syncWarm_q[1] &&
      cfgMode_q == MODE_SINGLE_ENDED |=> state_q == ST_RUN)
      else $error("single ended start-up did not skip check");

   chk_warn_level: assert property (warnS |=> thermalWarningOe)
      else $error("warning pin not low while hot");

   chk_trip_latch: assert property (tripS ##1 (resetPinS && !tripS) [*3]
      |-> tripLatch_q && alertLow_q && halfBridgeHiZ_q == 4'hf)
      else $error("thermal trip did not latch");

   chk_reset_release: assert property (!resetPinS && !checking ##1 (!resetPinS &&
      !checking && !tripS)
      |=> !alertLow_q && !tripLatch_q)
      else $error("reset low did not release alert and latch");

   chk_reset_hiz: assert property (!resetPinS |=> halfBridgeHiZ_q == 4'hf)
      else $error("reset low left a half-bridge active");

   chk_stuck_quiet: assert property (seqRunSettled ##0 (!globalOff &&
      overloadLatch_q == 4'h0 && stuckS == 4'h8) |=> halfBridgeHiZ_q == 4'h8 && !alertLow_q)
      else $error("missing pwm handled wrongly");

   chk_por_clear: assert property (logicLowS |=> overloadLatch_q == 4'h0
      && state_q == ST_POWER_ON)
      else $error("power-on did not clear overload");
endmodule : pfp_protect

/* File: pfp_sync.sv */
// Purpose: two flip-flop synchroniser for a vector of comparator flags
// Assumes: each bit is an independent level
// Notes:   bits may land one cycle apart; no bus coherency is promised
`timescale 1ns/100ps
module pfp_sync
   import pfp_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1)
   begin : g_chk
      $error("pfp_sync: WIDTH must be at least 1");
   end

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta_q <= '0;
         dout   <= '0;
      end
      else
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : pfp_sync

/* File: tb_power_stage_fault_protection.sv */
// Purpose: self-checking bench for the fault protection block
// Assumes: short check steps shortened to 8 cycles per uF
// Notes:   comparator and pin flags are driven directly as levels; no analog stage is modelled
`timescale 1ns/100ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin errorCnt++; \
   $display("ERROR %0t mismatch got %h exp %h", $time, (a), (e)); end end
module tb_power_stage_fault_protection;
   import pfp_pkg::*;
   logic clk = 0, reset = 1, regWr = 0, regRd = 0, resetPin_n = 1;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0, regRdata, d;
   logic logicSupplyLow = 1, gateSupplyLow = 0, outputSupplyLow = 0;
   logic tempWarn = 0, tempTrip = 0, shortToGnd = 0, shortToSupply = 0;
   logic [3:0] bootstrapLow = 4'h0, overload = 4'h0, pwmStuck = 4'h0;
   logic [3:0] halfBridgeHiZ, highSideOff;
   logic faultAlertOut_n, faultAlertOe, thermalWarningOut_n, thermalWarningOe;
   logic alertPin_n, warnPin_n, coolReq;
   int errorCnt = 0, samplesChecked = 0;
   always #5 clk = ~clk;
   pfp_protect #(.PSC_CYCLES(8)) u_dut (.clk(clk), .reset(reset), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .resetPin_n(resetPin_n), .logicSupplyLow(logicSupplyLow),
      .gateSupplyLow(gateSupplyLow), .outputSupplyLow(outputSupplyLow),
      .tempWarn(tempWarn), .tempTrip(tempTrip), .shortToGnd(shortToGnd),
      .shortToSupply(shortToSupply), .bootstrapLow(bootstrapLow), .overload(overload),
      .pwmStuck(pwmStuck), .halfBridgeHiZ(halfBridgeHiZ), .highSideOff(highSideOff),
      .faultAlertIn_n(alertPin_n), .faultAlertOut_n(faultAlertOut_n),
      .faultAlertOe(faultAlertOe), .thermalWarningIn_n(warnPin_n),
      .thermalWarningOut_n(thermalWarningOut_n), .thermalWarningOe(thermalWarningOe));
   pfp_ctrl_model u_ctrl (.faultAlertOut_n(faultAlertOut_n), .faultAlertOe(faultAlertOe),
      .thermalWarningOut_n(thermalWarningOut_n), .thermalWarningOe(thermalWarningOe),
      .alertPin_n(alertPin_n), .warnPin_n(warnPin_n), .coolReq(coolReq));
   task give_verdict;
      if (errorCnt == 0 && samplesChecked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a; regWdata <= v; regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      regAddr <= a; regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask : rd
   task wait_state(input logic [2:0] s);
      for (int i = 0; i < 300; i++)
      begin
         rd(ADDR_STATUS, d);
         if (d[2:0] === s) break;
      end
      `CHK(d[2:0], s)
   endtask : wait_state
   task pin_pulse;
      @(posedge clk) resetPin_n <= 1'b0;
      tick(5);
      @(posedge clk) resetPin_n <= 1'b1;
      tick(5);
   endtask : pin_pulse
   task restart;
      @(posedge clk) reset <= 1'b1;
      tick(2);
      @(posedge clk) reset <= 1'b0;
   endtask : restart
   task t_regs;
      rd(ADDR_CONFIG, d);
      `CHK(d, 32'h00000100)
      tick(1);
      `CHK(regRdata, 32'h00000000)
      rd(4'h8, d);
      `CHK(d, 32'h00000000)
      wr(ADDR_STATUS, 32'hffffffff);
      rd(ADDR_STATUS, d);
      `CHK(d[2:0], 3'h0)
      `CHK(halfBridgeHiZ, 4'hf)
   endtask : t_regs
   task t_boot;
      @(posedge clk) logicSupplyLow <= 1'b0;
      wait_state(3'h1);
      `CHK(faultAlertOe, 1'b1)
      `CHK(halfBridgeHiZ, 4'hf)
      wait_state(3'h2);
      wait_state(3'h4);
      tick(4);
      `CHK(faultAlertOe, 1'b0)
      `CHK(halfBridgeHiZ, 4'h0)
   endtask : t_boot
   task t_late_short;
      @(posedge clk) shortToGnd <= 1'b1;
      tick(10);
      rd(ADDR_STATUS, d);
      `CHK(d[2:0], 3'h4)
      `CHK(halfBridgeHiZ, 4'h0)
      @(posedge clk) shortToGnd <= 1'b0;
      @(posedge clk) resetPin_n <= 1'b0;
      tick(5);
      `CHK(halfBridgeHiZ, 4'hf)
      `CHK(faultAlertOe, 1'b0)
      rd(ADDR_STATUS, d);
      `CHK(d[2:0], 3'h4)
      @(posedge clk) resetPin_n <= 1'b1;
      tick(5);
      `CHK(halfBridgeHiZ, 4'h0)
   endtask : t_late_short
   task t_channel;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk) overload <= 4'h1 << i;
         @(posedge clk) overload <= 4'h0;
         tick(10);
         `CHK(halfBridgeHiZ, (i < 2) ? 4'h3 : 4'hc)
         `CHK(faultAlertOe, 1'b1)
         pin_pulse();
         `CHK(halfBridgeHiZ, 4'h0)
      end
      wr(ADDR_CONFIG, 32'h00000101);
      @(posedge clk) overload <= 4'h2;
      @(posedge clk) overload <= 4'h0;
      tick(5);
      `CHK(halfBridgeHiZ, 4'hf)
      pin_pulse();
      wr(ADDR_CONFIG, 32'h00000100);
      @(posedge clk) pwmStuck <= 4'h8;
      tick(5);
      `CHK(halfBridgeHiZ, 4'h8)
      `CHK(faultAlertOe, 1'b0)
      @(posedge clk) {pwmStuck, bootstrapLow} <= 8'h88;
      tick(5);
      `CHK(halfBridgeHiZ, 4'h8)
      `CHK(highSideOff, 4'h0)
      `CHK(faultAlertOe, 1'b0)
      @(posedge clk) {pwmStuck, bootstrapLow} <= 8'h00;
      @(posedge clk) bootstrapLow <= 4'h2;
      tick(5);
      `CHK(halfBridgeHiZ, 4'h0)
      `CHK(highSideOff, 4'h2)
      `CHK(faultAlertOe, 1'b0)
      @(posedge clk) bootstrapLow <= 4'h0;
      tick(5);
      `CHK(highSideOff, 4'h0)
   endtask : t_channel
   task t_uv;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk) {gateSupplyLow, outputSupplyLow} <= (k == 0) ? 2'b10 : 2'b01;
         tick(1);
         `CHK(halfBridgeHiZ, 4'h0)
         tick(5);
         `CHK(halfBridgeHiZ, 4'hf)
         `CHK(faultAlertOe, 1'b1)
         @(posedge clk) {gateSupplyLow, outputSupplyLow} <= 2'b00;
         tick(5);
         `CHK(halfBridgeHiZ, 4'h0)
         `CHK(faultAlertOe, 1'b0)
      end
      @(posedge clk) overload <= 4'h1;
      @(posedge clk) overload <= 4'h0;
      @(posedge clk) logicSupplyLow <= 1'b1;
      wait_state(3'h0);
      @(posedge clk) logicSupplyLow <= 1'b0;
      wait_state(3'h4);
      tick(4);
      `CHK(halfBridgeHiZ, 4'h0)
   endtask : t_uv
   task t_thermal;
      @(posedge clk) tempWarn <= 1'b1;
      tick(5);
      `CHK({alertPin_n, warnPin_n}, 2'b10)
      `CHK(coolReq, 1'b1)
      `CHK(halfBridgeHiZ, 4'h0)
      rd(ADDR_STATUS, d);
      `CHK(d[17:16], 2'b01)
      @(posedge clk) tempTrip <= 1'b1;
      tick(5);
      `CHK(halfBridgeHiZ, 4'hf)
      `CHK({alertPin_n, warnPin_n}, 2'b00)
      @(posedge clk) {tempTrip, tempWarn} <= 2'b00;
      tick(10);
      `CHK(halfBridgeHiZ, 4'hf)
      `CHK({alertPin_n, warnPin_n}, 2'b01)
      pin_pulse();
      `CHK(halfBridgeHiZ, 4'h0)
      `CHK({alertPin_n, warnPin_n}, 2'b11)
   endtask : t_thermal
   task t_boot_short;
      restart();
      wait_state(3'h2);
      @(posedge clk) shortToSupply <= 1'b1;
      wait_state(3'h3);
      @(posedge clk) resetPin_n <= 1'b0;
      tick(5);
      `CHK(faultAlertOe, 1'b1)
      `CHK(halfBridgeHiZ, 4'hf)
      @(posedge clk) resetPin_n <= 1'b1;
      tick(10);
      rd(ADDR_STATUS, d);
      `CHK(d[2:0], 3'h3)
      @(posedge clk) shortToSupply <= 1'b0;
      wait_state(3'h4);
      tick(4);
      `CHK(halfBridgeHiZ, 4'h0)
   endtask : t_boot_short
   task t_single;
      logic seen;
      seen = 1'b0;
      @(posedge clk) logicSupplyLow <= 1'b1;
      restart();
      wr(ADDR_CONFIG, 32'h00000100 | MODE_SINGLE_ENDED);
      @(posedge clk) logicSupplyLow <= 1'b0;
      repeat (12)
      begin
         rd(ADDR_STATUS, d);
         if (d[2:0] === 3'h1 || d[2:0] === 3'h2) seen = 1'b1;
      end
      `CHK(seen, 1'b0)
      `CHK(d[2:0], 3'h4)
   endtask : t_single
   initial
   begin
      #200us;
      errorCnt++;
      give_verdict();
   end
   initial
   begin
      tick(20);
      `CHK(halfBridgeHiZ, 4'hf)
      `CHK(faultAlertOe, 1'b0)
      @(posedge clk) reset <= 1'b0;
      t_regs();
      t_boot();
      t_late_short();
      t_channel();
      t_uv();
      t_thermal();
      t_boot_short();
      t_single();
      give_verdict();
   end
endmodule : tb_power_stage_fault_protection
